// *** core/serial_frame_rx.sv ***
// serial register port receiver: synchronises pins, shifts a frame, emits one write
`timescale 1ns/10ps
module serial_frame_rx
  import spindle_seq_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              serClk,     // serial bit clock pin
  input  wire logic              serData,    // serial data pin
  input  wire logic              serLoad,    // frame enable pin, high during a frame
  output logic                   wrStb_r,    // one-cycle pulse, complete frame
  output logic [ADDR_W-1:0]      wrAddr_r,   // register index of the frame
  output logic [DATA_W-1:0]      wrData_r    // data of the frame
);

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; stage one is read only by stage two
  logic [2:0] clkMeta_r;                     // [0] first stage, [1] second, [2] history
  logic [1:0] datMeta_r;
  logic [2:0] ldMeta_r;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      clkMeta_r <= 3'h0;
      datMeta_r <= 2'h0;
      ldMeta_r  <= 3'h0;
    end
    else
    begin
      clkMeta_r <= {clkMeta_r[1:0], serClk};
      datMeta_r <= {datMeta_r[0], serData};
      ldMeta_r  <= {ldMeta_r[1:0], serLoad};
    end
  end

  // edges seen on the synchronised copies only
  wire bitEdge  = clkMeta_r[1] & ~clkMeta_r[2] & ldMeta_r[1];
  wire frameEnd = ~ldMeta_r[1] & ldMeta_r[2];

  ////////////////////////////////////////////////////////////////////////
  // shift register and bit count
  logic [FRAME_BITS-1:0] shift_r;
  logic [4:0]            bitCnt_r;           // saturates above a full frame
  wire  [4:0]            bitCntInc = (bitCnt_r > FRAME_BITS_CNT) ? bitCnt_r : bitCnt_r + 5'h01;
  wire                   frameOk   = frameEnd & (bitCnt_r == FRAME_BITS_CNT);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      shift_r  <= '0;
      bitCnt_r <= 5'h00;
    end
    else if (frameEnd | ~ldMeta_r[1])
      bitCnt_r <= 5'h00;                     // idle between frames
    else if (bitEdge)
    begin
      shift_r  <= {shift_r[FRAME_BITS-2:0], datMeta_r[1]};
      bitCnt_r <= bitCntInc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // commit: a short or long frame is dropped, so partial data never reaches the decode
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      wrStb_r  <= 1'b0;
      wrAddr_r <= '0;
      wrData_r <= '0;
    end
    else
    begin
      wrStb_r <= frameOk;
      if (frameOk)
      begin
        wrAddr_r <= shift_r[FRAME_BITS-1:DATA_W];
        wrData_r <= shift_r[DATA_W-1:0];
      end
    end
  end

endmodule

// *** core/spindle_seq_pkg.sv ***
// constants, register map and types shared by the spindle sequencer control files
package spindle_seq_pkg;

  // register indices on the serial port (four address bits per frame)
  localparam logic [3:0]  SPIN_DRIVE_IDX   = 4'h2;   // spindle_drive_setting
  localparam logic [3:0]  SYS_MODE_IDX     = 4'h3;   // system_mode_control

  // frame layout: address then data, most significant bit first
  localparam int          ADDR_W           = 4;
  localparam int          DATA_W           = 12;
  localparam int          FRAME_BITS       = ADDR_W + DATA_W;
  localparam logic [4:0]  FRAME_BITS_CNT   = 5'h10;

  // values after reset
  localparam logic [11:0] SPIN_DRIVE_RST   = 12'h000;
  localparam logic [11:0] SYS_MODE_RST     = 12'h000;

  // field positions, spindle drive setting
  localparam int          DAC_LSB          = 0;
  localparam int          DAC_W            = 8;
  localparam int          DLY_LSB          = 8;
  localparam int          DLY_W            = 4;

  // field positions, system mode control
  localparam int          SPIN_EN_BIT      = 0;
  localparam int          ACT_EN_BIT       = 1;
  localparam int          SEQ_CLR_BIT      = 2;
  localparam int          STEP_BIT         = 3;
  localparam int          AUTO_BIT         = 4;
  localparam int          POLE_BIT         = 5;
  localparam int          SHAPE_HI_BIT     = 6;
  localparam int          SHAPE_LO_BIT     = 7;
  localparam int          PARK_BIT         = 8;
  localparam int          LOOP_BIT         = 9;
  localparam int          BASIS_BIT        = 10;
  localparam int          TEST_BIT         = 11;

  // delay step is 1.875 of the 60 degrees between crossings, i.e. period/32
  localparam int          DLY_SHIFT        = 5;
  localparam int          COMM_STATES      = 6;
  localparam logic [2:0]  LAST_COMM_STATE  = 3'h5;
  // electrical cycles per revolution, less one, for 8 and 12 pole motors
  localparam logic [2:0]  ELEC_PER_REV_8   = 3'h3;
  localparam logic [2:0]  ELEC_PER_REV_12  = 3'h5;

  // power modes decoded from the two enable bits
  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_PARK,
    MODE_IDLE,
    MODE_NORMAL
  } power_mode_t;

endpackage

// *** core/spindle_sequencer_control.sv ***
// spindle sequencer control: register decode, commutation delay and sequencer
// Overview of operation
// - spindle DAC takes low eight register bits
// - commutate after programmed delay past zero crossing
// - delay code gives 1.875 degree steps
// - enable bits decode sleep, idle, normal
// - spindle off, actuator on forces park
// - clear bit low holds sequencer, loop registers
// - charge pump off while clear bit high
// - step bit rising advances one state
// - auto bit selects run or search mode
// - pole bit selects eight or twelve poles
// - shape bits give tristate, bipolar, tripolar
// - park bit commands actuator retract
// - loop bit picks open or locked speed
// - basis bit picks electrical or mechanical period
// - test bit low clears test counter
// - status shows commutation delay running
// - power-on reset clears registers, port logic
`timescale 1ns/10ps
module spindle_sequencer_control
  import spindle_seq_pkg::*;
#(
  parameter int PERIOD_W = 16,              // crossing period counter width
  parameter int TEST_W   = 8                // test sequence counter width
)
(
  input  wire logic              clk_sys,
  input  wire logic              rst_b,          // power-on reset, active low
  input  wire logic              serClk,
  input  wire logic              serData,
  input  wire logic              serLoad,
  input  wire logic              bemfLevel,      // back-EMF comparator level pin
  output logic [DAC_W-1:0]       spinDacCode_r,  // spindle current limit DAC code
  output logic [DLY_W-1:0]       commutationDelayCode_r,
  output power_mode_t            powerMode_r,
  output logic                   actuatorFunctionOn_r,
  output logic                   actuatorParkCmd_r,  // retract or forced park
  output logic                   spindleTristate_r,
  output logic                   tripolarDrive_r,
  output logic                   chargePumpOff_r,
  output logic                   fllEnable_r,        // internal speed loop selected
  output logic                   cycleBasisSelect_r, // 1 electrical, 0 mechanical
  output logic                   loopClear_r,        // resets spindle and loop registers
  output logic                   testEnable_r,
  output logic [TEST_W-1:0]      testCount_r,
  output logic [2:0]             commState_r,        // sequencer state 0..5
  output logic                   commutatePulse_r,
  output logic                   delayActive_r,      // status: delay running
  output logic                   measureTick_r       // period end for the speed loop
);

  ////////////////////////////////////////////////////////////////////////
  // serial port
  logic              wrStb;
  logic [ADDR_W-1:0] wrAddr;
  logic [DATA_W-1:0] wrData;

  serial_frame_rx u_rx (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .serClk   (serClk),
    .serData  (serData),
    .serLoad  (serLoad),
    .wrStb_r  (wrStb),
    .wrAddr_r (wrAddr),
    .wrData_r (wrData)
  );

  ////////////////////////////////////////////////////////////////////////
  // write-only registers
  logic [DATA_W-1:0] spinDrive_r;            // spindle_drive_setting
  logic [DATA_W-1:0] sysMode_r;              // system_mode_control
  wire  wrSpin = wrStb & (wrAddr == SPIN_DRIVE_IDX);
  wire  wrMode = wrStb & (wrAddr == SYS_MODE_IDX);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      spinDrive_r <= SPIN_DRIVE_RST;
      sysMode_r   <= SYS_MODE_RST;
    end
    else
    begin
      if (wrSpin)
        spinDrive_r <= wrData;
      if (wrMode)
        sysMode_r <= wrData;
    end
  end

  wire stepNow = wrMode & wrData[STEP_BIT] & ~sysMode_r[STEP_BIT];

  ////////////////////////////////////////////////////////////////////////
  // field decode
  wire seqClear = ~sysMode_r[SEQ_CLR_BIT];
  wire autoStep = sysMode_r[AUTO_BIT];
  wire power_mode_t modeNxt = power_mode_t'({sysMode_r[SPIN_EN_BIT], sysMode_r[ACT_EN_BIT]});
  wire [2:0] elecPerRev = sysMode_r[POLE_BIT] ? ELEC_PER_REV_8 : ELEC_PER_REV_12;

  // delay in cycles: crossing period times code (code 0 taken as 1) over 32, at least one cycle
  function automatic logic [PERIOD_W-1:0] delayCycles(input logic [PERIOD_W-1:0] period,
                                                      input logic [DLY_W-1:0] code);
    logic [PERIOD_W+DLY_W-1:0] prod;
    logic [PERIOD_W+DLY_W-1:0] scaled;       // product over 32, still full width
    logic [DLY_W-1:0]          useCode;
    useCode = (code == '0) ? {{(DLY_W-1){1'b0}}, 1'b1} : code;
    prod    = period * useCode;
    // shift before narrowing: the quotient always fits, the raw product need not
    scaled  = prod >> DLY_SHIFT;
    delayCycles = (scaled == '0) ? {{(PERIOD_W-1){1'b0}}, 1'b1} : PERIOD_W'(scaled);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decoded outputs, all from flops
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      spinDacCode_r          <= '0;
      commutationDelayCode_r <= '0;
      powerMode_r            <= MODE_SLEEP;
      actuatorFunctionOn_r   <= 1'b0;
      actuatorParkCmd_r      <= 1'b0;
      spindleTristate_r      <= 1'b1;
      tripolarDrive_r        <= 1'b0;
      chargePumpOff_r        <= 1'b0;
      fllEnable_r            <= 1'b0;
      cycleBasisSelect_r     <= 1'b0;
      loopClear_r            <= 1'b1;
      testEnable_r           <= 1'b0;
    end
    else
    begin
      spinDacCode_r          <= spinDrive_r[DAC_LSB +: DAC_W];
      commutationDelayCode_r <= spinDrive_r[DLY_LSB +: DLY_W];
      powerMode_r            <= modeNxt;
      actuatorFunctionOn_r   <= (modeNxt == MODE_NORMAL);
      actuatorParkCmd_r      <= sysMode_r[PARK_BIT] | (modeNxt == MODE_PARK);
      // drive shape decode, undefined 01 treated as tristate
      spindleTristate_r      <= ~sysMode_r[SHAPE_HI_BIT];
      tripolarDrive_r        <= sysMode_r[SHAPE_HI_BIT] & sysMode_r[SHAPE_LO_BIT];
      chargePumpOff_r        <= sysMode_r[SEQ_CLR_BIT];
      fllEnable_r            <= sysMode_r[LOOP_BIT];
      cycleBasisSelect_r     <= sysMode_r[BASIS_BIT];
      loopClear_r            <= seqClear;
      testEnable_r           <= sysMode_r[TEST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // test sequence counter
  // test counter clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || !sysMode_r[TEST_BIT])
      testCount_r <= '0;
    else
      testCount_r <= testCount_r + {{(TEST_W-1){1'b0}}, 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////
  // back-EMF crossing detect, two flops before any logic
  logic [2:0] bemfSync_r;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      bemfSync_r <= 3'h0;
    else
      bemfSync_r <= {bemfSync_r[1:0], bemfLevel};
  end
  // a toggle either way is one zero crossing
  wire crossing = bemfSync_r[1] ^ bemfSync_r[2];

  ////////////////////////////////////////////////////////////////////////
  // crossing period measurement and commutation delay
  logic [PERIOD_W-1:0] periodCnt_r;          // cycles since last crossing
  logic [PERIOD_W-1:0] lastPeriod_r;         // latest full crossing period
  logic [PERIOD_W-1:0] delayCnt_r;
  wire  periodMax  = &periodCnt_r;
  wire  delayDone  = delayActive_r & (delayCnt_r == {{(PERIOD_W-1){1'b0}}, 1'b1});

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || seqClear)
    begin
      periodCnt_r   <= '0;
      lastPeriod_r  <= '0;
      delayCnt_r    <= '0;
      delayActive_r <= 1'b0;
    end
    else
    begin
      periodCnt_r <= crossing ? '0 : (periodMax ? periodCnt_r : periodCnt_r + 1'b1);
      // the count reads one less than the interval at the crossing cycle,
      // so add it back; otherwise a delay can come out one cycle short
      if (crossing)
        lastPeriod_r <= periodMax ? periodCnt_r : periodCnt_r + 1'b1;
      if (crossing && autoStep)
      begin
        delayCnt_r    <= delayCycles(lastPeriod_r, spinDrive_r[DLY_LSB +: DLY_W]);
        delayActive_r <= 1'b1;
      end
      else if (delayDone)
        delayActive_r <= 1'b0;
      else if (delayActive_r)
        delayCnt_r <= delayCnt_r - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // commutation sequencer and period ticks
  // run or search advance
  wire advance = autoStep ? delayDone : stepNow;
  wire wrapEl  = advance & (commState_r == LAST_COMM_STATE);
  logic [2:0] elecCnt_r;                     // electrical cycles in this revolution

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || seqClear)
    begin
      commState_r      <= 3'h0;
      elecCnt_r        <= 3'h0;
      commutatePulse_r <= 1'b0;
      measureTick_r    <= 1'b0;
    end
    else
    begin
      commutatePulse_r <= advance;
      if (advance)
        commState_r <= wrapEl ? 3'h0 : commState_r + 3'h1;
      if (wrapEl)
        elecCnt_r <= (elecCnt_r >= elecPerRev) ? 3'h0 : elecCnt_r + 3'h1;
      measureTick_r <= wrapEl & (sysMode_r[BASIS_BIT] | (elecCnt_r >= elecPerRev));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // dac follows register
  dac_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !wrSpin ##1 !wrSpin |=> spinDacCode_r == $past(spinDrive_r[7:0]))
    else $error("dac code does not follow register");
  delay_commute_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    autoStep && !seqClear && delayDone && !$past(seqClear) |=> commutatePulse_r)
    else $error("delay expiry did not commutate");
  delay_status_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    crossing && autoStep && !seqClear |=> delayActive_r)
    else $error("delay status not raised");
  search_nodelay_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    crossing && !autoStep && !delayActive_r |=> !delayActive_r)
    else $error("delay started in search mode");
  park_force_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !sysMode_r[0] && sysMode_r[1] |=> actuatorParkCmd_r && powerMode_r == MODE_PARK)
    else $error("park not forced");
  seq_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seqClear |=> commState_r == 3'h0 && !delayActive_r && loopClear_r)
    else $error("sequencer not held in clear");
  pump_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sysMode_r[SEQ_CLR_BIT] |=> chargePumpOff_r)
    else $error("charge pump not off");
  step_adv_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepNow && !autoStep && !seqClear |=> commState_r != $past(commState_r) ##1 !seqClear)
    else $error("step did not advance");
  shape_dec_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sysMode_r[7:6] == 2'b11 |=> tripolarDrive_r && !spindleTristate_r)
    else $error("tripolar not decoded");
  test_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !sysMode_r[TEST_BIT] |=> testCount_r == '0 && !testEnable_r)
    else $error("test counter not cleared");
  frame_only_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !wrStb |=> $stable(sysMode_r) && $stable(spinDrive_r))
    else $error("register changed without frame");

endmodule

// *** dv/serial_host_model.sv ***
// processor-side model: serial register writes and back-EMF crossings
`timescale 1ns/10ps
module serial_host_model
  import spindle_seq_pkg::*;
(
  input  wire logic clk_sys,
  output logic      serClk,
  output logic      serData,
  output logic      serLoad,
  output logic      bemfLevel
);
  // bit clock stands still low between frames
  initial
  begin
    serClk    = 1'b0;
    serData   = 1'b0;
    serLoad   = 1'b0;
    bemfLevel = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one frame, index then data, msb first; fewer than 16 bits makes a bad frame
  task automatic send_frame(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] data,
                            input int nbits);
    logic [FRAME_BITS-1:0] word;
    word = {idx, data};
    @(negedge clk_sys);
    serLoad = 1'b1;
    for (int i = 0; i < nbits; i++)
    begin
      serData = word[FRAME_BITS-1-i];
      repeat (3) @(negedge clk_sys);
      serClk = 1'b1;
      repeat (3) @(negedge clk_sys);
      serClk = 1'b0;
    end
    serLoad = 1'b0;
    // released data line: inverse of the last bit, so no stale bit looks valid
    serData = ~serData;
    // long enough for the write to reach the decoded outputs
    repeat (10) @(negedge clk_sys);
  endtask

  task automatic write_mode(input logic [DATA_W-1:0] val);
    logic [DATA_W-1:0] w;
    w = val;
    // run mode always carries the step bit high
    if (w[AUTO_BIT])
      w[STEP_BIT] = 1'b1;
    // the undefined shape code is never sent
    if (w[SHAPE_LO_BIT] && !w[SHAPE_HI_BIT])
      w[SHAPE_LO_BIT] = 1'b0;
    send_frame(SYS_MODE_IDX, w, FRAME_BITS);
  endtask

  // back-EMF zero crossings, evenly spaced by gap cycles
  task automatic crossings(input int n, input int gap);
    repeat (n)
    begin
      repeat (gap) @(negedge clk_sys);
      bemfLevel = ~bemfLevel;
    end
  endtask
endmodule

// *** dv/test_spindle_sequencer_control.sv ***
// self-checking bench: serial writes, decoded outputs and sequencer timing
`timescale 1ns/10ps
module test_spindle_sequencer_control
  import spindle_seq_pkg::*;
;
  logic              clk_sys, rst_b, serClk, serData, serLoad, bemfLevel;
  logic [DAC_W-1:0]  spinDacCode_r;
  logic [DLY_W-1:0]  commutationDelayCode_r;
  power_mode_t       powerMode_r;
  logic              actuatorFunctionOn_r, actuatorParkCmd_r, spindleTristate_r;
  logic              tripolarDrive_r, chargePumpOff_r, fllEnable_r, cycleBasisSelect_r;
  logic              loopClear_r, testEnable_r, commutatePulse_r, delayActive_r;
  logic              measureTick_r;
  logic [7:0]        testCount_r;
  logic [2:0]        commState_r;
  int                nMismatch, checksDone, nPulse, nTick, delayCycles;
  logic [DATA_W-1:0] v;
  logic [DATA_W-1:0] fieldVals [7];
  logic [DATA_W-1:0] runVals [3];
  int                tickExp [3];

  spindle_sequencer_control dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .serClk(serClk), .serData(serData),
    .serLoad(serLoad), .bemfLevel(bemfLevel), .spinDacCode_r(spinDacCode_r),
    .commutationDelayCode_r(commutationDelayCode_r), .powerMode_r(powerMode_r),
    .actuatorFunctionOn_r(actuatorFunctionOn_r), .actuatorParkCmd_r(actuatorParkCmd_r),
    .spindleTristate_r(spindleTristate_r), .tripolarDrive_r(tripolarDrive_r),
    .chargePumpOff_r(chargePumpOff_r), .fllEnable_r(fllEnable_r),
    .cycleBasisSelect_r(cycleBasisSelect_r), .loopClear_r(loopClear_r),
    .testEnable_r(testEnable_r), .testCount_r(testCount_r), .commState_r(commState_r),
    .commutatePulse_r(commutatePulse_r), .delayActive_r(delayActive_r),
    .measureTick_r(measureTick_r));

  serial_host_model host_u (.clk_sys(clk_sys), .serClk(serClk), .serData(serData),
                            .serLoad(serLoad), .bemfLevel(bemfLevel));

  ////////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // pulses are one cycle wide, so they are counted rather than sampled later
  always @(posedge clk_sys)
  begin
    if (commutatePulse_r === 1'b1) nPulse++;
    if (measureTick_r === 1'b1) nTick++;
    if (delayActive_r === 1'b1) delayCycles++;
  end

  // watchdog: the tests need about 20k cycles
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    nMismatch++;
    printVerdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checksDone++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // outputs expected straight after a reset
  task automatic resetChk();
    chk("dac", 16'h0000, spinDacCode_r);
    chk("mode", 16'h0000, powerMode_r);
    chk("tristate", 16'h0001, spindleTristate_r);
    chk("loopClear", 16'h0001, loopClear_r);
    chk("state", 16'h0000, commState_r);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    fieldVals = '{12'h004, 12'h040, 12'h0c0, 12'h100, 12'h200, 12'h400, 12'h800};
    runVals   = '{12'h4df, 12'h0ff, 12'h0df};
    tickExp   = '{12, 3, 2};
    rst_b = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    resetChk();
    $display("test reset done");
    // full frame to the drive register, then a short frame and a foreign index
    host_u.send_frame(SPIN_DRIVE_IDX, 12'h5c3, FRAME_BITS);
    chk("dac", 16'h00c3, spinDacCode_r);
    chk("delayCode", 16'h0005, commutationDelayCode_r);
    host_u.send_frame(SPIN_DRIVE_IDX, 12'ha3c, FRAME_BITS - 1);
    chk("dac", 16'h00c3, spinDacCode_r);
    host_u.send_frame(4'h4, 12'hfff, FRAME_BITS);
    chk("dac", 16'h00c3, spinDacCode_r);
    chk("mode", 16'h0000, powerMode_r);
    $display("test frames done");
    // every enable combination
    for (int m = 0; m < 4; m++)
    begin
      v = DATA_W'(m);
      host_u.write_mode(v);
      chk("mode", {14'h0, v[0], v[1]}, powerMode_r);
      chk("actOn", 16'(m == 3), actuatorFunctionOn_r);
      chk("park", 16'(m == 2), actuatorParkCmd_r);
    end
    $display("test modes done");
    // one field at a time
    foreach (fieldVals[i])
    begin
      v = fieldVals[i];
      host_u.write_mode(v);
      chk("pumpOff", 16'(v[2]), chargePumpOff_r);
      chk("loopClear", 16'(!v[2]), loopClear_r);
      chk("tristate", 16'(!v[6]), spindleTristate_r);
      chk("tripolar", 16'(v[6] & v[7]), tripolarDrive_r);
      chk("park", 16'(v[8]), actuatorParkCmd_r);
      chk("fll", 16'(v[9]), fllEnable_r);
      chk("basis", 16'(v[10]), cycleBasisSelect_r);
      chk("testEn", 16'(v[11]), testEnable_r);
      chk("testRun", 16'(v[11]), 16'(testCount_r != 8'h00));
    end
    $display("test fields done");
    // search mode: only rising step writes advance, past the wrap
    // release the sequencer clear first, a step written while clear is held is lost
    host_u.write_mode(12'h004);
    nPulse = 0;
    for (int i = 1; i <= 7; i++)
    begin
      host_u.write_mode(12'h00c);
      host_u.write_mode(12'h00c);
      host_u.write_mode(12'h004);
      chk("state", 16'(i % COMM_STATES), commState_r);
    end
    chk("pulses", 16'd7, nPulse);
    delayCycles = 0;
    host_u.crossings(3, 64);
    chk("searchDelay", 16'd0, delayCycles);
    chk("state", 16'd1, commState_r);
    host_u.write_mode(12'h000);
    chk("state", 16'd0, commState_r);
    $display("test search done");
    // run mode: delay of code 4 on a 64-cycle crossing period is 8 cycles
    host_u.send_frame(SPIN_DRIVE_IDX, 12'h4c3, FRAME_BITS);
    host_u.write_mode(12'h0df);
    host_u.crossings(4, 64);
    delayCycles = 0;
    nPulse = 0;
    host_u.crossings(4, 64);
    repeat (40) @(negedge clk_sys);
    // the delay of the last warm-up crossing falls inside the window too
    chk("delayLen", 16'(5 * ((64 * 4) >> DLY_SHIFT)), delayCycles);
    chk("pulses", 16'd5, nPulse);
    $display("test run done");
    // period ticks over 72 commutations for each basis and pole count
    foreach (runVals[i])
    begin
      host_u.write_mode(runVals[i] & 12'hffb);
      host_u.write_mode(runVals[i]);
      nTick = 0;
      host_u.crossings(72, 64);
      repeat (40) @(negedge clk_sys);
      chk("ticks", 16'(tickExp[i]), nTick);
    end
    $display("test ticks done");
    // reset in mid-run clears everything again
    rst_b = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    resetChk();
    $display("test rerun reset done");
    printVerdict();
  end
endmodule
